// ---- verilog/rhts_hint_tagger.sv ----
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module rhts_hint_tagger
   import rhts_pkg::*;
#(
   parameter int unsigned TBL_DEPTH   = 64,
   parameter logic [1:0]  TABLE_PLACE = PLACE_CAP,
   parameter bit          HAS_VECTOR  = 1'b1,
   parameter bit          HAS_VENDOR  = 1'b1,
   parameter bit          CMPL_HINTS  = 1'b1
) (
   input  wire logic              pclk,     // Clock, 20 MHz
   input  wire logic              presetn,  // Async reset, low
   input  wire logic              psel,     // APB select
   input  wire logic              penable,  // APB enable
   input  wire logic              pwrite,   // APB direction
   input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
   input  wire logic [31:0]       pwdata,   // APB write data
   input  wire logic [3:0]        pstrb,    // APB byte strobes
   output logic      [31:0]       prdata,   // APB read data
   output logic                   pready,   // APB ready
   output logic                   pslverr,  // APB error
   input  wire rhts_pkg::rhts_req_t req,    // Request from generator
   output rhts_pkg::rhts_hdr_t    hdr       // Header hint fields, reg
);
   import rhts_pkg::*;

   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [2:0]  mode;
      logic        enable;
      logic        msix_en;
      logic        msi_en;
      logic [2:0]  mme;
      logic [31:0] rdata;
      logic        err;
      logic        ready;
      rhts_hdr_t   hdr;
      logic [15:0] hdr_count;
      logic [15:0] fault_count;
   } rhts_state_t;

   rhts_state_t s_q, s_d;

   ////////////////////////////////////////////////////////////////////
   logic                 setup;
   logic                 tbl_we;
   logic [TBL_IDX_W-1:0] tbl_widx;
   logic [TAG_W-1:0]     tbl_wdata;
   logic [TBL_IDX_W-1:0] bus_idx;
   logic [TAG_W-1:0]     bus_tag;
   logic [TBL_IDX_W-1:0] hdr_idx;
   logic [TAG_W-1:0]     hdr_tag;
   logic [2:0]           eff_mode;
   logic [TBL_IDX_W:0]   idx_limit;
   logic                 in_tbl;
   logic                 in_vm;
   logic [31:0]          cap_word;

   assign setup = psel && !penable;
   assign in_tbl = (paddr >= OFF_TABLE) && (paddr < OFF_VMASK);
   // Mask bank is as long as the table bank; anything above is unmapped
   assign in_vm  = (paddr >= OFF_VMASK)
                   && (paddr < OFF_VMASK + (OFF_VMASK - OFF_TABLE));
   assign bus_idx = paddr[TBL_IDX_W+1:2];

   rhts_tag_table #(
      .DEPTH (TBL_DEPTH),
      .IW    (TBL_IDX_W),
      .TW    (TAG_W)
   ) u_table (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (tbl_we),
      .widx    (tbl_widx),
      .wdata   (tbl_wdata),
      .ridx_a  (bus_idx),
      .rdata_a (bus_tag),
      .ridx_b  (hdr_idx),
      .rdata_b (hdr_tag)
   );

   // Capability word: modes, completer bit, place, size
   always_comb begin
      cap_word = '0;
      cap_word[CAP_ZERO_B] = 1'b1;
      cap_word[CAP_VEC_B]  = HAS_VECTOR;
      cap_word[CAP_VEND_B] = HAS_VENDOR;
      cap_word[CAP_CMPL_B] = CMPL_HINTS;
      cap_word[CAP_PLACE_LO +: 2] = TABLE_PLACE;
      cap_word[CAP_SIZE_LO +: 11] = 11'(TBL_DEPTH - 1);
   end

   // One place only: table bank vs. mask-word bank
   always_comb begin
      tbl_we    = 1'b0;
      tbl_widx  = bus_idx;
      tbl_wdata = pwdata[TAG_W-1:0];
      // Misaligned writes are refused, so they must not touch the table
      if (psel && penable && pwrite && paddr[1:0] == 2'b00) begin
         if (in_tbl && TABLE_PLACE == PLACE_CAP) begin
            tbl_we = pstrb[1] && pstrb[0];
         end else if (in_vm && TABLE_PLACE == PLACE_VECTOR) begin
            tbl_we    = pstrb[3] && pstrb[2];
            tbl_wdata = pwdata[VM_TAG_LO +: TAG_W];
         end
      end
   end

   // Reserved or unsupported modes fall back to zero tags
   always_comb begin
      eff_mode = MODE_ZERO;
      if (s_q.mode == MODE_VECTOR && HAS_VECTOR) begin
         eff_mode = MODE_VECTOR;
      end else if (s_q.mode == MODE_VENDOR && HAS_VENDOR) begin
         eff_mode = MODE_VENDOR;
      end
   end

   // Vector bound: MSI grant (2^mme) or MSI-X table size
   always_comb begin
      idx_limit = (TBL_IDX_W+1)'(TBL_DEPTH);
      if (s_q.msi_en) begin
         // Shift only while it fits, so a large grant cannot wrap to zero
         if (s_q.mme <= 3'(TBL_IDX_W)) begin
            idx_limit = (TBL_IDX_W+1)'(1) << s_q.mme;
         end
         if (idx_limit > (TBL_IDX_W+1)'(TBL_DEPTH)) begin
            idx_limit = (TBL_IDX_W+1)'(TBL_DEPTH);
         end
      end
   end

   assign hdr_idx = req.index;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d       = s_q;
      s_d.ready = 1'b0;
      // APB: answer one cycle after setup
      if (setup) begin
         s_d.ready = 1'b1;
         s_d.err   = 1'b0;
         s_d.rdata = '0;
         if (paddr[1:0] != 2'b00) begin
            s_d.err = 1'b1;
         end else if (paddr == OFF_CAP) begin
            s_d.rdata = cap_word;
            s_d.err   = pwrite;
         end else if (paddr == OFF_CTRL) begin
            s_d.rdata[CTL_MODE_LO +: 3] = s_q.mode;
            s_d.rdata[CTL_EN_B]         = s_q.enable;
            s_d.rdata[CTL_MSIX_B]       = s_q.msix_en;
            s_d.rdata[CTL_MSI_B]        = s_q.msi_en;
            s_d.rdata[CTL_MME_LO +: 3]  = s_q.mme;
         end else if (paddr == OFF_STATUS) begin
            s_d.rdata = {s_q.fault_count, s_q.hdr_count};
            s_d.err   = pwrite;
         end else if (in_tbl && bus_idx < TBL_IDX_W'(TBL_DEPTH - 1)
                      || in_tbl && bus_idx == TBL_IDX_W'(TBL_DEPTH - 1)) begin
            if (TABLE_PLACE == PLACE_CAP) begin
               s_d.rdata[TAG_W-1:0] = bus_tag;
            end
         end else if (in_vm) begin
            if (TABLE_PLACE == PLACE_VECTOR) begin
               s_d.rdata[VM_TAG_LO +: TAG_W] = bus_tag;
            end
         end else begin
            s_d.err = 1'b1;
         end
      end
      if (psel && penable && pwrite && paddr == OFF_CTRL) begin
         if (pstrb[0]) begin
            s_d.mode = pwdata[CTL_MODE_LO +: 3];
         end
         if (pstrb[1]) begin
            s_d.enable  = pwdata[CTL_EN_B];
            s_d.msix_en = pwdata[CTL_MSIX_B];
            s_d.msi_en  = pwdata[CTL_MSI_B];
            s_d.mme     = pwdata[CTL_MME_LO +: 3];
         end
      end

      // Header build, one register stage
      s_d.hdr = '0;
      if (req.valid) begin
         s_d.hdr.valid = 1'b1;
         // Memory access controls live upstream and stay untouched
         if (req.mem_space && req.hint_valid && s_q.enable) begin
            s_d.hdr.hint_present = 1'b1;
            s_d.hdr.hint_code    = req.hint_code;
            s_d.hdr.cache_target_tag = '0;
            case (eff_mode)
               MODE_VECTOR: begin
                  if ({1'b0, req.index} < idx_limit) begin
                     s_d.hdr.cache_target_tag = hdr_tag;
                  end else begin
                     s_d.hdr.index_fault = 1'b1;
                  end
               end
               MODE_VENDOR: begin
                  if (req.use_index) begin
                     s_d.hdr.cache_target_tag = hdr_tag;
                  end else begin
                     s_d.hdr.cache_target_tag = req.explicit_tag;
                  end
               end
               default: begin
                  s_d.hdr.cache_target_tag = '0;
               end
            endcase
            s_d.hdr_count = s_q.hdr_count + 16'h0001;
            if (s_d.hdr.index_fault) begin
               s_d.fault_count = s_q.fault_count + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata  = s_q.rdata;
   assign pready  = s_q.ready;
   assign pslverr = s_q.ready & s_q.err;
   assign hdr     = s_q.hdr;

   ////////////////////////////////////////////////////////////////////
   // Checks

   property p_no_hint_disabled;
      @(posedge pclk) disable iff (!presetn)
      (req.valid && !s_q.enable) |=> !hdr.hint_present;
   endproperty
   a_no_hint_disabled: assert property (p_no_hint_disabled)
      else $error("hint attached while disabled");

   property p_mem_only;
      @(posedge pclk) disable iff (!presetn)
      (req.valid && !req.mem_space) |=> (hdr.valid && !hdr.hint_present);
   endproperty
   a_mem_only: assert property (p_mem_only)
      else $error("hint on non-memory request");

   property p_zero_mode;
      @(posedge pclk) disable iff (!presetn)
      (req.valid && s_q.mode == MODE_ZERO)
         |=> hdr.cache_target_tag == '0;
   endproperty
   a_zero_mode: assert property (p_zero_mode)
      else $error("nonzero tag in zero tag mode");

   property p_reserved_mode;
      @(posedge pclk) disable iff (!presetn)
      (req.valid && s_q.mode > MODE_VENDOR)
         |=> hdr.cache_target_tag == '0;
   endproperty
   a_reserved_mode: assert property (p_reserved_mode)
      else $error("nonzero tag in reserved mode");

   property p_hint_pass;
      @(posedge pclk) disable iff (!presetn)
      (req.valid && req.mem_space && req.hint_valid && s_q.enable)
         |=> hdr.hint_present && hdr.hint_code == $past(req.hint_code);
   endproperty
   a_hint_pass: assert property (p_hint_pass)
      else $error("hint code not carried");

   property p_vec_bound;
      @(posedge pclk) disable iff (!presetn)
      (req.valid && req.mem_space && req.hint_valid && s_q.enable
       && eff_mode == MODE_VECTOR && {1'b0, req.index} >= idx_limit)
         |=> hdr.index_fault && hdr.cache_target_tag == '0;
   endproperty
   a_vec_bound: assert property (p_vec_bound)
      else $error("vector index beyond grant used");

   property p_vec_tag;
      @(posedge pclk) disable iff (!presetn)
      (req.valid && req.mem_space && req.hint_valid && s_q.enable
       && eff_mode == MODE_VECTOR && {1'b0, req.index} < idx_limit)
         |=> hdr.cache_target_tag == $past(hdr_tag);
   endproperty
   a_vec_tag: assert property (p_vec_tag)
      else $error("vector tag not from table");

   sequence s_apb_setup;
      psel && !penable;
   endsequence
   sequence s_apb_done;
      pready ##1 !pready;
   endsequence
   property p_apb_answer;
      @(posedge pclk) disable iff (!presetn)
      s_apb_setup |=> s_apb_done;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer not one cycle after setup");

   property p_cap_place;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == OFF_CAP)
         |=> prdata[CAP_PLACE_LO +: 2] == TABLE_PLACE
             && prdata[CAP_ZERO_B];
   endproperty
   a_cap_place: assert property (p_cap_place)
      else $error("capability word wrong");

endmodule

// ---- shared/rhts_pkg.sv ----
package rhts_pkg;

   localparam int unsigned TAG_W     = 16;
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned TBL_IDX_W = 6;

   // Hint codes
   localparam logic [1:0] HINT_BIDIR     = 2'h0;
   localparam logic [1:0] HINT_REQUESTER = 2'h1;
   localparam logic [1:0] HINT_TARGET    = 2'h2;
   localparam logic [1:0] HINT_TGT_PRIO  = 2'h3;

   // Tag mode select encodings
   localparam logic [2:0] MODE_ZERO   = 3'h0;
   localparam logic [2:0] MODE_VECTOR = 3'h1;
   localparam logic [2:0] MODE_VENDOR = 3'h2;

   // Tag table place encodings
   localparam logic [1:0] PLACE_NONE   = 2'h0;
   localparam logic [1:0] PLACE_CAP    = 2'h1;
   localparam logic [1:0] PLACE_VECTOR = 2'h2;

   // Register byte offsets
   localparam logic [11:0] OFF_CAP    = 12'h000;
   localparam logic [11:0] OFF_CTRL   = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [11:0] OFF_TABLE  = 12'h100;
   localparam logic [11:0] OFF_VMASK  = 12'h200;

   // CAP fields
   localparam int unsigned CAP_ZERO_B   = 0;
   localparam int unsigned CAP_VEC_B    = 1;
   localparam int unsigned CAP_VEND_B   = 2;
   localparam int unsigned CAP_CMPL_B   = 3;
   localparam int unsigned CAP_PLACE_LO = 8;
   localparam int unsigned CAP_SIZE_LO  = 16;
   // CTRL fields, then the tag position in a mask-bank word
   localparam int unsigned CTL_MODE_LO  = 0;
   localparam int unsigned CTL_EN_B     = 8;
   localparam int unsigned CTL_MSIX_B   = 9;
   localparam int unsigned CTL_MSI_B    = 10;
   localparam int unsigned CTL_MME_LO   = 12;
   localparam int unsigned VM_TAG_LO    = 16;

   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

   typedef struct packed {
      logic                 valid;
      logic                 mem_space;
      logic                 hint_valid;
      logic [1:0]           hint_code;
      logic                 use_index;
      logic [TBL_IDX_W-1:0] index;
      logic [TAG_W-1:0]     explicit_tag;
   } rhts_req_t;

   typedef struct packed {
      logic             valid;
      logic             hint_present;
      logic [1:0]       hint_code;
      logic [TAG_W-1:0] cache_target_tag;
      logic             index_fault;
   } rhts_hdr_t;

endpackage

// ---- verilog/rhts_tag_table.sv ----
`timescale 1ns/1ps
module rhts_tag_table #(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned IW    = 6,
   parameter int unsigned TW    = 16
) (
   input  wire logic          pclk,    // Clock
   input  wire logic          presetn, // Async reset, low
   input  wire logic          we,      // Write strobe
   input  wire logic [IW-1:0] widx,    // Write index
   input  wire logic [TW-1:0] wdata,   // Write tag
   input  wire logic [IW-1:0] ridx_a,  // Read index, bus
   output logic      [TW-1:0] rdata_a, // Read tag, bus
   input  wire logic [IW-1:0] ridx_b,  // Read index, header
   output logic      [TW-1:0] rdata_b  // Read tag, header
);
   logic [TW-1:0] mem_q [DEPTH];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      end else if (we) begin
         mem_q[widx] <= wdata;
      end
   end

   // Combinational read so the header sees the tag in its own cycle
   assign rdata_a = mem_q[ridx_a];
   assign rdata_b = mem_q[ridx_b];
endmodule

// ---- tb/rhts_cmpl_model.sv ----
`timescale 1ns/1ps
module rhts_cmpl_model
   import rhts_pkg::*;
(
   input  wire logic          pclk,     // Clock
   input  wire logic          presetn,  // Async reset, low
   input  wire rhts_pkg::rhts_hdr_t hdr, // Header from requester
   output rhts_pkg::rhts_hdr_t last_hdr, // Last header taken
   output logic [15:0]        n_hdr     // Headers taken
);
   // Completer takes every header; hints only steer, never refuse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_hdr <= '0;
         n_hdr    <= 16'h0000;
      end else if (hdr.valid) begin
         last_hdr <= hdr;
         n_hdr    <= n_hdr + 16'h0001;
      end
   end
endmodule

// ---- tb/rhts_hint_tagger_tb.sv ----
`timescale 1ns/1ps
module rhts_hint_tagger_tb;
   import rhts_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rdat;
   logic [3:0]        pstrb;
   logic              pready, pslverr, rerr;
   rhts_req_t         req;
   rhts_hdr_t         hdr, last_hdr;
   logic [15:0]       n_hdr;
   int                err_count, comparisons, cycles, nh, nf, nreq;
   localparam logic [5:0] IXS [4] = '{6'h00, 6'h01, 6'h02, 6'h3F};

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   rhts_hint_tagger i_dut (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .req     (req),
      .hdr     (hdr)
   );

   rhts_cmpl_model i_cmpl (
      .pclk     (pclk),
      .presetn  (presetn),
      .hdr      (hdr),
      .last_hdr (last_hdr),
      .n_hdr    (n_hdr)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Ceiling well above the fewer than two hundred cycles the tests need
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         $display("mismatch at %0t: timeout", $time);
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Waits as long as it takes; only the bench timeout ends a hang
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(32'(n), 32'h0000_0001, "pready wait");
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic xe);
      apb(1'b1, a, d);
      chk(32'(rerr), 32'(xe), "write error flag");
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
      apb(1'b0, a, 32'h0000_0000);
      chk(32'(rerr), 32'(xe), "read error flag");
      if (!xe)
         chk(rdat, x, "read data");
   endtask

   function automatic logic [15:0] tv(input logic [5:0] ix);
      return 16'hC300 | {10'h000, ix};
   endfunction

   // One request, header checked where the completer took it
   task automatic snd(input logic mem, input logic hv, input logic [1:0] c,
                      input logic ui, input logic [5:0] ix,
                      input logic [15:0] et, input logic hp,
                      input logic [15:0] xt, input logic xf);
      @(posedge pclk);
      req <= '{1'b1, mem, hv, c, ui, ix, et};
      @(posedge pclk);
      req.valid <= 1'b0;
      @(posedge pclk);
      #1;
      nreq++;
      nh += int'(hp);
      nf += int'(xf);
      chk(32'({last_hdr.valid, last_hdr.hint_present,
               last_hdr.cache_target_tag, last_hdr.index_fault}),
          32'({1'b1, hp, xt, xf}), "header");
      if (hp)
         chk(32'(last_hdr.hint_code), 32'(c), "hint code");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      req = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFF_CAP, 32'h003F_010F, 1'b0);
      rd(OFF_CTRL, CTRL_RESET, 1'b0);
      rd(OFF_STATUS, 32'h0000_0000, 1'b0);
      wr(OFF_CAP, 32'hFFFF_FFFF, 1'b1);
      wr(12'h010, 32'h0000_0000, 1'b1);
      rd(12'h006, 32'h0000_0000, 1'b1);
      rd(OFF_CAP, 32'h003F_010F, 1'b0);
      snd(1, 1, HINT_REQUESTER, 0, 6'h00, 16'h0000, 0, 16'h0000, 0);
      wr(OFF_CTRL, 32'h0000_0100, 1'b0);
      for (int i = 0; i < 4; i++)
         snd(1, 1, 2'(i), 0, 6'h00, 16'h0000, 1, 16'h0000, 0);
      snd(0, 1, HINT_TARGET, 0, 6'h00, 16'h0000, 0, 16'h0000, 0);
      snd(1, 0, HINT_TARGET, 0, 6'h00, 16'h0000, 0, 16'h0000, 0);
      // Hints off while the table is rewritten
      wr(OFF_CTRL, 32'h0000_0000, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_TABLE + 12'({IXS[i], 2'b00}), 32'(tv(IXS[i])), 1'b0);
         rd(OFF_TABLE + 12'({IXS[i], 2'b00}), 32'(tv(IXS[i])), 1'b0);
      end
      wr(OFF_TABLE + 12'h006, 32'h0000_1234, 1'b1);
      rd(OFF_TABLE + 12'h004, 32'(tv(6'h01)), 1'b0);
      wr(OFF_VMASK + 12'h004, 32'hABCD_0000, 1'b0);
      rd(OFF_VMASK + 12'h004, 32'h0000_0000, 1'b0);
      rd(OFF_TABLE + 12'h004, 32'(tv(6'h01)), 1'b0);
      rd(12'h300, 32'h0000_0000, 1'b1);
      wr(OFF_CTRL, 32'h0000_0301, 1'b0);
      for (int i = 0; i < 4; i++)
         snd(1, 1, HINT_BIDIR, 1, IXS[i], 16'h0000, 1, tv(IXS[i]), 0);
      wr(OFF_CTRL, 32'h0000_1501, 1'b0);
      snd(1, 1, HINT_TARGET, 1, 6'h01, 16'h0000, 1, tv(6'h01), 0);
      snd(1, 1, HINT_TARGET, 1, 6'h02, 16'h0000, 1, 16'h0000, 1);
      wr(OFF_CTRL, 32'h0000_0102, 1'b0);
      snd(1, 1, HINT_TGT_PRIO, 1, 6'h02, 16'h0000, 1, tv(6'h02), 0);
      snd(1, 1, HINT_TGT_PRIO, 0, 6'h02, 16'hBEEF, 1, 16'hBEEF, 0);
      for (int m = 3; m < 8; m++) begin
         wr(OFF_CTRL, 32'h0000_0100 | 32'(m), 1'b0);
         snd(1, 1, HINT_TARGET, 1, 6'h01, 16'hBEEF, 1, 16'h0000, 0);
      end
      rd(OFF_STATUS, {nf[15:0], nh[15:0]}, 1'b0);
      chk(32'(n_hdr), 32'(nreq), "header count");
      end_sim();
   end
endmodule
